/* interval_timer_regs.svh */
// Register offsets, field positions, reset values and prescale taps of the interval timer.
// Behaviour
// - Clock select 00/01/10/11 picks clock divided by 8/32/128/512; 00 after reset.
// - A channel counter advances on its prescaled tick only while its run bit is 1.
// - Each channel counter is a 16-bit up-counter, readable and writable by software.
// - Counter equal to period: counter clears to zero and the match flag sets.
// - After a match clear the counter keeps counting from zero, repeating the period.
// - Channel interrupt request goes high one enabled clock after match flag and interrupt enable are both 1.
// - Each channel drives its own separate interrupt request line.
// - Power-on reset sets the counter to zero.
// - Power-on reset sets the 16-bit period register to all ones.
// - Match acts on the next counter tick after equality, not on first equal cycle.
// - Match flag clears only by writing 0 after reading it as 1; writing 1 keeps it set but cancels the read.
// - A match during a counter write clears the counter and discards the written value.
// - An increment during a word write to the counter is lost; written value stored.
// - Increment during byte write: written byte stored, other byte keeps old value.
// - Interrupt enable 1 lets the match interrupt request rise; 0 blocks MATCH_IRQ, but the combined IRQ still rises via event status and mask.
// - Shared run register: bit 0 runs channel 0, bit 1 channel 1; both 0 at reset.
// - Control/status: match flag bit 7, enable bit 6, clock select bits 1:0; others 0.
`ifndef INTERVAL_TIMER_REGS_SVH
`define INTERVAL_TIMER_REGS_SVH

`define OFS_RUN        5'h00
`define OFS_CTRL0      5'h02
`define OFS_COUNT0     5'h04
`define OFS_PERIOD0    5'h06
`define OFS_CTRL1      5'h08
`define OFS_COUNT1     5'h0a
`define OFS_PERIOD1    5'h0c
`define OFS_EVT_STATUS 5'h0e
`define OFS_EVT_MASK   5'h10

`define BIT_FLAG       7
`define BIT_IRQ_EN     6
`define BIT_SEL_HI     1
`define BIT_SEL_LO     0

`define RST_COUNT      16'h0000
`define RST_PERIOD     16'hffff
`define RST_SEL        2'h0

`define TAP_DIV8       3
`define TAP_DIV32      5
`define TAP_DIV128     7
`define TAP_DIV512     9

`endif

/* interval_timer_pkg.sv */
// Types shared by the interval timer.
package interval_timer_pkg;

    typedef struct packed {
        logic       flag;
        logic       irq_en;
        logic [1:0] sel;
    } chan_ctrl_t;

    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic [1:0]  be;
        logic        wr;
        logic        rd;
    } bus_req_t;

endpackage : interval_timer_pkg

/* interval_timer.sv */
// Two-channel compare match interval timer with its register port and interrupt logic.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "interval_timer_regs.svh"

module interval_timer #(
    parameter int DIV_W = `TAP_DIV512
) (
    // Clock, reset and clock enable.
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    // Register port.
    input  wire logic [4:0]  BUS_ADDR,
    input  wire logic [15:0] BUS_WDATA,
    input  wire logic [1:0]  BUS_BE,
    input  wire logic        BUS_WR,
    input  wire logic        BUS_RD,
    output logic      [15:0] BUS_RDATA,
    // Interrupt requests.
    output logic      [1:0]  MATCH_IRQ,
    output logic             IRQ
);

    localparam int NCH = 2;

    generate
        if (DIV_W < `TAP_DIV512) begin : g_bad_div
            $error("DIV_W must be at least the widest prescale tap.");
        end
    endgenerate

    // Returns the prescale tick selected by a clock-select code.
    function automatic logic tap_tick(input logic [1:0] sel, input logic [DIV_W-1:0] div);
        logic t;
        t = 1'b0;
        unique case (sel)
            2'h0: t = &div[`TAP_DIV8-1:0];
            2'h1: t = &div[`TAP_DIV32-1:0];
            2'h2: t = &div[`TAP_DIV128-1:0];
            2'h3: t = &div[`TAP_DIV512-1:0];
        endcase
        return t;
    endfunction : tap_tick

    // Merges write data into an old value by byte lanes.
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
        logic [15:0] m;
        m = old;
        if (be[0]) begin
            m[7:0] = wd[7:0];
        end
        if (be[1]) begin
            m[15:8] = wd[15:8];
        end
        return m;
    endfunction : merge

    interval_timer_pkg::bus_req_t req;
    assign req = '{addr: BUS_ADDR, wdata: BUS_WDATA, be: BUS_BE, wr: BUS_WR, rd: BUS_RD};

    logic [DIV_W-1:0]                   div_r;
    logic [NCH-1:0]                     run_r;
    logic [NCH-1:0]                     evt_status_r;
    logic [NCH-1:0]                     evt_mask_r;
    logic [NCH-1:0]                     match_pulse;
    logic [15:0]                        cnt_w   [NCH];
    logic [15:0]                        per_w   [NCH];
    interval_timer_pkg::chan_ctrl_t     ctrl_w  [NCH];
    logic [15:0]                        rd_nxt;

    // Free-running prescaler shared by both channels.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            div_r <= '0;
        end else if (CE) begin
            div_r <= div_r + 1'b1;
        end
    end

    // Shared run register.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            run_r <= '0;
        end else if (CE && req.wr && req.addr == `OFS_RUN && req.be[0]) begin
            run_r <= req.wdata[NCH-1:0];
        end
    end

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            localparam logic [4:0] A_CTRL = (c == 0) ? `OFS_CTRL0 : `OFS_CTRL1;
            localparam logic [4:0] A_CNT  = (c == 0) ? `OFS_COUNT0 : `OFS_COUNT1;
            localparam logic [4:0] A_PER  = (c == 0) ? `OFS_PERIOD0 : `OFS_PERIOD1;

            logic [15:0]                    cnt_r;
            logic [15:0]                    per_r;
            logic                           flag_r;
            logic                           irq_en_r;
            logic [1:0]                     sel_r;
            logic                           seen_r;
            logic                           tick;
            logic                           wr_cnt;
            logic                           wr_ctrl;

            assign tick    = CE && run_r[c] && tap_tick(sel_r, div_r);
            assign wr_cnt  = CE && req.wr && req.addr == A_CNT;
            assign wr_ctrl = CE && req.wr && req.addr == A_CTRL && req.be[0];
            // Equality acts only when the next tick arrives.
            assign match_pulse[c] = tick && (cnt_r == per_r);

            // Counter: match clear beats a write, a write beats an increment.
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    cnt_r <= `RST_COUNT;
                end else if (match_pulse[c]) begin
                    cnt_r <= '0;
                end else if (wr_cnt) begin
                    cnt_r <= merge(cnt_r, req.wdata, req.be);
                end else if (tick) begin
                    cnt_r <= cnt_r + 16'h0001;
                end
            end

            // Period register.
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    per_r <= `RST_PERIOD;
                end else if (CE && req.wr && req.addr == A_PER) begin
                    per_r <= merge(per_r, req.wdata, req.be);
                end
            end

            // Enable and clock select.
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    irq_en_r <= 1'b0;
                    sel_r    <= `RST_SEL;
                end else if (wr_ctrl) begin
                    irq_en_r <= req.wdata[`BIT_IRQ_EN];
                    sel_r    <= req.wdata[`BIT_SEL_HI:`BIT_SEL_LO];
                end
            end

            // Read of a set flag arms the clear; any write to the register's low byte disarms it.
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    seen_r <= 1'b0;
                end else if (wr_ctrl) begin
                    seen_r <= 1'b0;
                end else if (CE && req.rd && req.addr == A_CTRL && flag_r) begin
                    seen_r <= 1'b1;
                end
            end

            // Match flag: a match in the clearing cycle wins.
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    flag_r <= 1'b0;
                end else if (match_pulse[c]) begin
                    flag_r <= 1'b1;
                end else if (wr_ctrl && seen_r && !req.wdata[`BIT_FLAG]) begin
                    flag_r <= 1'b0;
                end
            end

            // Per-channel interrupt line.
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    MATCH_IRQ[c] <= 1'b0;
                end else if (CE) begin
                    MATCH_IRQ[c] <= flag_r && irq_en_r;
                end
            end

            assign cnt_w[c]  = cnt_r;
            assign per_w[c]  = per_r;
            assign ctrl_w[c] = '{flag: flag_r, irq_en: irq_en_r, sel: sel_r};
        end
    endgenerate

    // Sticky event status, write one to clear; a new match wins over the clear.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            evt_status_r <= '0;
        end else if (CE) begin
            if (req.wr && req.addr == `OFS_EVT_STATUS && req.be[0]) begin
                evt_status_r <= (evt_status_r & ~req.wdata[NCH-1:0]) | match_pulse;
            end else begin
                evt_status_r <= evt_status_r | match_pulse;
            end
        end
    end

    // Event mask.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            evt_mask_r <= '0;
        end else if (CE && req.wr && req.addr == `OFS_EVT_MASK && req.be[0]) begin
            evt_mask_r <= req.wdata[NCH-1:0];
        end
    end

    // Combined interrupt output.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else if (CE) begin
            IRQ <= |(evt_status_r & evt_mask_r);
        end
    end

    // Read multiplexer; unmapped offsets read zero.
    always_comb begin
        rd_nxt = 16'h0000;
        unique case (req.addr)
            `OFS_RUN:        rd_nxt[NCH-1:0] = run_r;
            `OFS_CTRL0:      rd_nxt = {8'h00, ctrl_w[0].flag, ctrl_w[0].irq_en,
                                       4'h0, ctrl_w[0].sel};
            `OFS_COUNT0:     rd_nxt = cnt_w[0];
            `OFS_PERIOD0:    rd_nxt = per_w[0];
            `OFS_CTRL1:      rd_nxt = {8'h00, ctrl_w[1].flag, ctrl_w[1].irq_en,
                                       4'h0, ctrl_w[1].sel};
            `OFS_COUNT1:     rd_nxt = cnt_w[1];
            `OFS_PERIOD1:    rd_nxt = per_w[1];
            `OFS_EVT_STATUS: rd_nxt[NCH-1:0] = evt_status_r;
            `OFS_EVT_MASK:   rd_nxt[NCH-1:0] = evt_mask_r;
            default:         rd_nxt = 16'h0000;
        endcase
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            BUS_RDATA <= 16'h0000;
        end else if (CE) begin
            BUS_RDATA <= req.rd ? rd_nxt : 16'h0000;
        end
    end

endmodule : interval_timer

/* interval_timer_props.sv */
// Port-level assertions for the interval timer, bound to its top module.
`timescale 1ns/1ps
`include "interval_timer_regs.svh"

module interval_timer_props (
    // Clock, reset and clock enable.
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic        CE,
    // Register port.
    input wire logic [4:0]  BUS_ADDR,
    input wire logic [15:0] BUS_WDATA,
    input wire logic [1:0]  BUS_BE,
    input wire logic        BUS_WR,
    input wire logic        BUS_RD,
    input wire logic [15:0] BUS_RDATA,
    // Interrupt requests.
    input wire logic [1:0]  MATCH_IRQ,
    input wire logic        IRQ
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    a_reset_quiet: assert property ($fell(RST) |-> !IRQ && MATCH_IRQ == 2'h0)
        else $error("Interrupt active right after reset.");
    a_rdata_idle: assert property (!$past(BUS_RD) |-> BUS_RDATA == 16'h0000)
        else $error("Read data outside its cycle.");
    a_rd_unmapped: assert property ($past(BUS_RD) && $past(BUS_ADDR) > 5'h10 |-> BUS_RDATA == 16'h0000)
        else $error("Unmapped read not zero.");
    a_run_rsvd: assert property ($past(BUS_RD) && $past(BUS_ADDR) == `OFS_RUN
        |-> BUS_RDATA[15:2] == 14'h0000) else $error("Run register spare bits set.");
    a_ctrl_rsvd: assert property ($past(BUS_RD)
        && ($past(BUS_ADDR) == `OFS_CTRL0 || $past(BUS_ADDR) == `OFS_CTRL1)
        |-> BUS_RDATA[15:8] == 8'h00 && BUS_RDATA[5:2] == 4'h0)
        else $error("Control spare bits set.");
    a_irq0_fall: assert property ($fell(MATCH_IRQ[0])
        |-> $past(BUS_WR, 2) && $past(BUS_ADDR, 2) == `OFS_CTRL0)
        else $error("Channel 0 request dropped without a control write.");
    a_irq1_fall: assert property ($fell(MATCH_IRQ[1])
        |-> $past(BUS_WR, 2) && $past(BUS_ADDR, 2) == `OFS_CTRL1)
        else $error("Channel 1 request dropped without a control write.");
    a_sum_fall: assert property ($fell(IRQ)
        |-> $past(BUS_WR, 2) && $past(BUS_ADDR, 2) inside {`OFS_EVT_STATUS, `OFS_EVT_MASK})
        else $error("Combined request dropped without a status or mask write.");
endmodule : interval_timer_props

bind interval_timer interval_timer_props props_u (
    .CORE_CLK  (CORE_CLK),
    .RST       (RST),
    .CE        (CE),
    .BUS_ADDR  (BUS_ADDR),
    .BUS_WDATA (BUS_WDATA),
    .BUS_BE    (BUS_BE),
    .BUS_WR    (BUS_WR),
    .BUS_RD    (BUS_RD),
    .BUS_RDATA (BUS_RDATA),
    .MATCH_IRQ (MATCH_IRQ),
    .IRQ       (IRQ)
);

/* interval_timer_test.sv */
// Self-checking testbench for the two-channel interval timer.
`timescale 1ns/1ps
`include "interval_timer_regs.svh"

module interval_timer_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic [1:0]  be = 2'h3;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        ce = 1'b1;
    logic [15:0] rdata;
    logic [1:0]  mirq;
    logic        irq;
    int          num_errors = 0;
    int          num_checks = 0;
    logic [4:0]  reg_addr [10] = '{`OFS_RUN, `OFS_CTRL0, `OFS_COUNT0, `OFS_PERIOD0, `OFS_CTRL1,
        `OFS_COUNT1, `OFS_PERIOD1, `OFS_EVT_STATUS, `OFS_EVT_MASK, 5'h12};
    logic [15:0] reg_rst [10] = '{16'h0, 16'h0, 16'h0, 16'hffff, 16'h0, 16'h0, 16'hffff,
        16'h0, 16'h0, 16'h0};

    always #10 clk = ~clk;

    interval_timer dut_u (
        .CORE_CLK (clk), .RST (rst), .CE (ce), .BUS_ADDR (addr), .BUS_WDATA (wdata),
        .BUS_BE (be), .BUS_WR (wr), .BUS_RD (rd), .BUS_RDATA (rdata), .MATCH_IRQ (mirq),
        .IRQ (irq)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d, input logic [1:0] b = 2'h3);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : rd_chk

    task automatic catch_match(input logic [15:0] ctl);
        int n;
        n = 0;
        rd_chk(`OFS_CTRL1, ctl);
        wr_reg(`OFS_CTRL1, 16'h0040);
        wr_reg(`OFS_COUNT1, 16'h0000);
        wr_reg(`OFS_RUN, 16'h0002);
        do begin
            @(negedge clk);
            n++;
        end while (mirq[1] !== 1'b1 && n < 200);
        check(mirq, 2'h2);
    endtask : catch_match

    task automatic complete_run;
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run;
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) rd_chk(reg_addr[i], reg_rst[i]);
        wr_reg(`OFS_COUNT0, 16'h1234);
        repeat (40) @(posedge clk);
        rd_chk(`OFS_COUNT0, 16'h1234);
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(`OFS_COUNT0, 16'h0bad);
        ce <= 1'b1;
        rd_chk(`OFS_COUNT0, 16'h1234);
        for (int s = 0; s < 4; s++) begin
            wr_reg(`OFS_CTRL0, 16'(s));
            wr_reg(`OFS_COUNT0, 16'h0000);
            wr_reg(`OFS_RUN, 16'h0001);
            repeat (3 * (8 << (2 * s)) - 2) @(posedge clk);
            wr_reg(`OFS_RUN, 16'h0000);
            rd_chk(`OFS_COUNT0, 16'h0003);
            rd_chk(`OFS_CTRL0, 16'(s));
        end
        wr_reg(`OFS_PERIOD1, 16'h0003);
        wr_reg(`OFS_CTRL1, 16'h0040);
        wr_reg(`OFS_COUNT1, 16'h0003);
        repeat (20) @(posedge clk);
        rd_chk(`OFS_CTRL1, 16'h0040);
        catch_match(16'h0040);
        repeat (5) @(posedge clk);
        wr_reg(`OFS_COUNT1, 16'h0100);
        wr_reg(`OFS_RUN, 16'h0000);
        rd_chk(`OFS_COUNT1, 16'h0100);
        catch_match(16'h00c0);
        repeat (5) @(posedge clk);
        wr_reg(`OFS_COUNT1, 16'h1200, 2'h2);
        wr_reg(`OFS_RUN, 16'h0000);
        rd_chk(`OFS_COUNT1, 16'h1200);
        catch_match(16'h00c0);
        rd_chk(`OFS_COUNT1, 16'h0000);
        repeat (27) @(posedge clk);
        wr_reg(`OFS_COUNT1, 16'h0055);
        wr_reg(`OFS_RUN, 16'h0000);
        rd_chk(`OFS_COUNT1, 16'h0000);
        rd_chk(`OFS_CTRL1, 16'h00c0);
        wr_reg(`OFS_CTRL1, 16'h00c0);
        wr_reg(`OFS_CTRL1, 16'h0040);
        rd_chk(`OFS_CTRL1, 16'h00c0);
        wr_reg(`OFS_CTRL1, 16'h0040);
        #41 check(mirq, 2'h0);
        wr_reg(`OFS_CTRL1, 16'h0000);
        wr_reg(`OFS_COUNT1, 16'h0000);
        wr_reg(`OFS_RUN, 16'h0002);
        repeat (40) @(posedge clk);
        wr_reg(`OFS_RUN, 16'h0000);
        #1 check(mirq, 2'h0);
        rd_chk(`OFS_CTRL1, 16'h0080);
        rd_chk(`OFS_EVT_STATUS, 16'h0002);
        wr_reg(`OFS_EVT_MASK, 16'h0002);
        #41 check(irq, 1'b1);
        wr_reg(`OFS_EVT_STATUS, 16'h0002);
        #41 check(irq, 1'b0);
        wr_reg(`OFS_CTRL1, 16'h00c0);
        #41 check(mirq, 2'h2);
        complete_run;
    end
endmodule : interval_timer_test
